// file: common/tmr_pkg.sv
/*
  Package for the basic up-counting time-base timer: register offsets,
  field positions, reset values and carrier types.
  Assumes a plain register port with one-cycle read latency.
*/
`default_nettype none

package tmr_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_EVGEN  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRESC  = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 5'h14;

  // timer_control_one fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_UDIS    = 1;
  localparam int unsigned CTRL_URS     = 2;
  localparam int unsigned CTRL_ARBUF   = 7;
  localparam int unsigned CTRL_IRQEN   = 8;
  localparam int unsigned CTRL_DMAEN   = 9;
  // timer_status_reg / event_generate_reg fields
  localparam int unsigned STS_UPD      = 0;
  localparam int unsigned EVG_UPD      = 0;

  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [15:0] RST_PRESC    = 16'h0000;
  localparam logic [15:0] RST_RELOAD   = 16'hFFFF;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic irq;
    logic dma_req;
  } tmr_req_s;

endpackage

`default_nettype wire

// file: dv/tb_basic_upcount_timer.sv
/*
  Self-checking testbench for the basic up-counting timer: register
  accesses, overflow periods, buffered reload and prescaler, update
  disable, request source, slave update and debug freeze.
  Assumes the register port of tmr_pkg with one-cycle read latency.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_basic_upcount_timer
  import tmr_pkg::*;
;
  logic        clk;
  logic        arst_n;
  reg_req_s    bus;
  logic [15:0] rdata;
  logic        slave_update;
  logic        core_halted;
  logic        debug_halt_freeze;
  tmr_req_s    req;
  logic        overflow;
  logic        update_event;
  int          err_total;
  int          n_tests;
  int          upd_cnt;
  int          dma_cnt;
  int          ovf_cnt;
  int          n;
  logic [15:0] a;
  logic [15:0] b;

  basic_upcount_timer dut (
    .clk               (clk),
    .arst_n            (arst_n),
    .bus               (bus),
    .rdata             (rdata),
    .slave_update      (slave_update),
    .core_halted       (core_halted),
    .debug_halt_freeze (debug_halt_freeze),
    .req               (req),
    .overflow          (overflow),
    .update_event      (update_event)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (update_event === 1'b1) upd_cnt++;
    if (req.dma_req === 1'b1) dma_cnt++;
    if (overflow === 1'b1) ovf_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] ad, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= ad;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // data sampled at the edge closing the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [15:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= ad;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] ad, input logic [15:0] exp);
    logic [15:0] v;
    rd(ad, v);
    chk(v, exp);
  endtask

  // cycles until the next update pulse, bounded
  task automatic wait_upd(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (update_event !== 1'b1 && c < 300);
    if (c >= 300) chk(16'hDEAD, 16'h0000);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_total++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    bus = '0;
    slave_update = 1'b0;
    core_halted = 1'b0;
    debug_halt_freeze = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rchk(OFF_RELOAD, RST_RELOAD);
    rchk(OFF_COUNT, RST_COUNT);
    rchk(OFF_PRESC, RST_PRESC);
    rchk(5'h1C, 16'h0000);
    wr(OFF_RELOAD, 16'h0005);
    rchk(OFF_RELOAD, 16'h0005);
    // enable, reload buffering, irq and dma
    wr(OFF_CTRL, 16'h0381);
    rchk(OFF_CTRL, 16'h0381);
    wait_upd(n);
    wait_upd(n);
    chk(16'(n), 16'h0006);
    rchk(OFF_STATUS, 16'h0001);
    chk({15'h0, req.irq}, 16'h0001);
    wait_upd(n);
    wr(OFF_RELOAD, 16'h0009);
    // old period of 6 still runs; the write used 2 of its cycles
    wait_upd(n);
    chk(16'(n), 16'h0004);
    wait_upd(n);
    chk(16'(n), 16'h000A);
    rchk(OFF_RELOAD, 16'h0009);
    wait_upd(n);
    wr(OFF_PRESC, 16'h0001);
    // old period of 10 still runs; the write used 2 of its cycles
    wait_upd(n);
    chk(16'(n), 16'h0008);
    wait_upd(n);
    chk(16'(n), 16'h0014);
    rchk(OFF_PRESC, 16'h0001);
    wr(OFF_STATUS, 16'h0000);
    rchk(OFF_STATUS, 16'h0000);
    chk({15'h0, req.irq}, 16'h0000);
    chk(16'(dma_cnt), 16'(upd_cnt));
    // updates disabled: wraps continue, no update pulses
    wr(OFF_CTRL, 16'h0383);
    n = upd_cnt;
    a = 16'(ovf_cnt);
    wr(OFF_PRESC, 16'h0000);
    repeat (60) @(posedge clk);
    chk(16'(upd_cnt), 16'(n));
    chk({15'h0, 16'(ovf_cnt) > a}, 16'h0001);
    wr(OFF_EVGEN, 16'h0001);
    rd(OFF_COUNT, a);
    chk({15'h0, a < 16'h0003}, 16'h0001);
    chk(16'(upd_cnt), 16'(n));
    // request source set: generate updates silently
    wr(OFF_CTRL, 16'h0385);
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_EVGEN, 16'h0001);
    wait_upd(n);
    chk({15'h0, n < 4}, 16'h0001);
    rchk(OFF_STATUS, 16'h0000);
    rchk(OFF_EVGEN, 16'h0000);
    // skip the partial period cut by the reads
    wait_upd(n);
    wait_upd(n);
    chk(16'(n), 16'h000A);
    @(posedge clk);
    slave_update <= 1'b1;
    @(posedge clk);
    slave_update <= 1'b0;
    wait_upd(n);
    chk({15'h0, n < 4}, 16'h0001);
    // debug halt with freeze, then without
    core_halted <= 1'b1;
    debug_halt_freeze <= 1'b1;
    repeat (5) @(posedge clk);
    rd(OFF_COUNT, a);
    rd(OFF_COUNT, b);
    chk(b, a);
    debug_halt_freeze <= 1'b0;
    repeat (5) @(posedge clk);
    rd(OFF_COUNT, a);
    rd(OFF_COUNT, b);
    chk({15'h0, b != a}, 16'h0001);
    core_halted <= 1'b0;
    wr(OFF_CTRL, 16'h0000);
    rd(OFF_COUNT, a);
    rd(OFF_COUNT, b);
    chk(b, a);
    wr(OFF_COUNT, 16'h0003);
    rchk(OFF_COUNT, 16'h0003);
    complete_run();
  end
endmodule

`default_nettype wire

// file: verilog/basic_upcount_timer.sv
/*
  Basic 16-bit auto-reload up counter with a buffered 16-bit prescaler,
  update event logic, and a plain register port.
  Assumes: one clock, strobes from logic on the same clock; debug halt and
  debug-freeze inputs come from another domain and are synchronised here.
*/
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - counter runs 0 to reload value, wraps to zero, flags overflow.
// - 16-bit prescaler divides clock by any ratio 1 to 65536.
// - prescaler writes apply only at the next update event.
// - count, reload and prescaler are readable and writable any time.
// - reload accesses hit preload; shadow copies immediately or at update.
// - with updates enabled, overflow makes an update event.
// - counter advances on ticks only while effective enable, one cycle late.
// - update-generate bit from software or slave produces an update event.
// - update-disable blocks update events and freezes shadow values except unbuffered reload writes.
// - with updates disabled, generate still restarts counter and prescaler.
// - request-source set: generate updates without flag, irq or dma.
// - update reloads prescaler and reload shadows, sets flag as permitted.
// - update flag can raise interrupt or dma request.
// - counter clock is internal only; prescaler runs once enable is one.
// - enable and generate set by software; generate clears itself.
// - debug halt freezes counter when debug-freeze configured.
// - reload buffering zero writes shadow directly; one holds until update.
module basic_upcount_timer
  import tmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire reg_req_s    bus,
  output var  logic [15:0] rdata,
  input  wire logic        slave_update,
  input  wire logic        core_halted,
  input  wire logic        debug_halt_freeze,
  output var  tmr_req_s    req,
  output var  logic        overflow,
  output var  logic        update_event
);

  if (DATA_W != 16) begin : g_width_check
    $error("timer data width must be 16");
  end

  logic [15:0] ctrl;
  logic        update_flag;
  logic        update_generate_bit;
  logic [15:0] count_value_reg;
  logic [15:0] prescale_setting_reg;
  logic [15:0] prescale_active;
  logic [15:0] prescale_cnt;
  logic [15:0] reload_value_reg;
  logic [15:0] reload_shadow;
  logic        effective_count_enable;
  logic [1:0]  halt_sync;
  logic [1:0]  frz_sync;

  logic counter_enable_bit;
  logic update_disable;
  logic update_request_source;
  logic reload_buffer_enable;
  assign counter_enable_bit    = ctrl[CTRL_EN_BIT];
  assign update_disable        = ctrl[CTRL_UDIS];
  assign update_request_source = ctrl[CTRL_URS];
  assign reload_buffer_enable  = ctrl[CTRL_ARBUF];

  logic wr_ctrl, wr_sts, wr_evg, wr_cnt, wr_psc, wr_arr;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_sts  = 1'b0;
    wr_evg  = 1'b0;
    wr_cnt  = 1'b0;
    wr_psc  = 1'b0;
    wr_arr  = 1'b0;
    // unmapped addresses fall through, so writes there are dropped
    if (bus.wr && bus.addr == OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (bus.wr && bus.addr == OFF_STATUS) begin
      wr_sts = 1'b1;
    end else if (bus.wr && bus.addr == OFF_EVGEN) begin
      wr_evg = 1'b1;
    end else if (bus.wr && bus.addr == OFF_COUNT) begin
      wr_cnt = 1'b1;
    end else if (bus.wr && bus.addr == OFF_PRESC) begin
      wr_psc = 1'b1;
    end else if (bus.wr && bus.addr == OFF_RELOAD) begin
      wr_arr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // debug halt inputs arrive from the debug domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_sync <= 2'h0;
      frz_sync  <= 2'h0;
    end else begin
      halt_sync <= {halt_sync[0], core_halted};
      frz_sync  <= {frz_sync[0], debug_halt_freeze};
    end
  end

  logic frozen;
  assign frozen = halt_sync[1] && frz_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // event decode
  logic counter_tick;
  logic at_top;
  logic ovf;
  logic gen_req;
  logic uev;
  logic flag_set;
  assign counter_tick = effective_count_enable && !frozen
                        && (prescale_cnt == prescale_active);
  assign at_top   = (count_value_reg >= reload_shadow);
  assign ovf      = counter_tick && at_top;
  // generate bit is held one cycle, then cleared by hardware
  assign gen_req  = update_generate_bit || slave_update;
  assign uev      = !update_disable && (ovf || gen_req);
  assign flag_set = !update_disable
                    && (ovf || (gen_req && !update_request_source));

  ////////////////////////////////////////////////////////////////////////////////
  // control and event-generation bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 16'h0000;
    end else if (wr_ctrl) begin
      ctrl <= bus.wdata & 16'h0387;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      update_generate_bit <= 1'b0;
    end else begin
      update_generate_bit <= wr_evg && bus.wdata[EVG_UPD];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      effective_count_enable <= 1'b0;
    end else begin
      effective_count_enable <= counter_enable_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_setting_reg <= RST_PRESC;
    end else if (wr_psc) begin
      prescale_setting_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_active <= RST_PRESC;
    end else if (uev) begin
      prescale_active <= prescale_setting_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_cnt <= 16'h0000;
    end else if (gen_req) begin
      prescale_cnt <= 16'h0000;
    end else if (effective_count_enable && !frozen) begin
      prescale_cnt <= counter_tick ? 16'h0000 : prescale_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // auto-reload preload and shadow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_value_reg <= RST_RELOAD;
    end else if (wr_arr) begin
      reload_value_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_shadow <= RST_RELOAD;
    end else if (wr_arr && !reload_buffer_enable) begin
      reload_shadow <= bus.wdata;
    end else if (uev) begin
      reload_shadow <= reload_value_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_value_reg <= RST_COUNT;
    end else if (wr_cnt) begin
      count_value_reg <= bus.wdata;
    end else if (gen_req) begin
      count_value_reg <= 16'h0000;
    end else if (counter_tick) begin
      count_value_reg <= at_top ? 16'h0000 : count_value_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flag: hardware set wins over software clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      update_flag <= 1'b0;
    end else if (flag_set) begin
      update_flag <= 1'b1;
    end else if (wr_sts && !bus.wdata[STS_UPD]) begin
      update_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req          <= '0;
      overflow     <= 1'b0;
      update_event <= 1'b0;
    end else begin
      req.irq      <= (flag_set || update_flag) && ctrl[CTRL_IRQEN];
      req.dma_req  <= flag_set && ctrl[CTRL_DMAEN];
      overflow     <= ovf;
      update_event <= uev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (!bus.rd) begin
      rdata <= 16'h0000;
    end else if (bus.addr == OFF_CTRL) begin
      rdata <= ctrl;
    end else if (bus.addr == OFF_STATUS) begin
      rdata <= {15'h0000, update_flag};
    end else if (bus.addr == OFF_COUNT) begin
      rdata <= count_value_reg;
    end else if (bus.addr == OFF_PRESC) begin
      rdata <= prescale_setting_reg;
    end else if (bus.addr == OFF_RELOAD) begin
      rdata <= reload_value_reg;
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_wrap;
    counter_tick && at_top;
  endsequence

  wrap_to_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_wrap and (!wr_cnt && !gen_req) |=> count_value_reg == 16'h0000)
    else $error("counter did not wrap to zero");

  enable_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(counter_enable_bit) |-> !effective_count_enable ##1 effective_count_enable)
    else $error("effective enable not one cycle late");

  presc_buffer_a: assert property (@(posedge clk) disable iff (!arst_n)
    !uev |=> $stable(prescale_active))
    else $error("prescaler changed without update");

  ovf_update_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf && !update_disable && !wr_arr |=> update_event && reload_shadow == $past(reload_value_reg))
    else $error("overflow gave no update");

  gen_update_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_evg && bus.wdata[0] && !update_disable |=> ##1 update_event)
    else $error("generate bit gave no update");

  udis_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
    update_disable && !wr_arr |=> $stable(reload_shadow) && !update_event)
    else $error("shadow changed while updates disabled");

  gen_restart_a: assert property (@(posedge clk) disable iff (!arst_n)
    gen_req && !wr_cnt |=> count_value_reg == 16'h0000 && prescale_cnt == 16'h0000)
    else $error("generate did not restart counter");

  urs_noflag_a: assert property (@(posedge clk) disable iff (!arst_n)
    gen_req && !ovf && update_request_source && !update_flag && !wr_sts |=> !update_flag)
    else $error("flag set by masked source");

  gen_selfclear_a: assert property (@(posedge clk) disable iff (!arst_n)
    update_generate_bit && !(wr_evg && bus.wdata[0]) |=> !update_generate_bit)
    else $error("generate bit not cleared");

  freeze_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    frozen && !wr_cnt && !gen_req |=> $stable(count_value_reg))
    else $error("counter moved while frozen");

  // flag, request, reload-path, prescaler-gap and stopped-counter checks
  sequence s_enable_off;
    !counter_enable_bit ##1 (!counter_enable_bit && !gen_req && !wr_cnt);
  endsequence

  flag_set_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    flag_set |=> update_flag)
    else $error("update flag lost a same-cycle set");

  irq_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    flag_set && ctrl[CTRL_IRQEN] |=> req.irq)
    else $error("flagged update gave no interrupt request");

  dma_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    flag_set && ctrl[CTRL_DMAEN] |=> req.dma_req)
    else $error("flagged update gave no dma request");

  direct_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_arr && !reload_buffer_enable |=> reload_shadow == $past(bus.wdata))
    else $error("unbuffered reload write missed the shadow");

  held_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_arr && reload_buffer_enable && !uev |=> $stable(reload_shadow))
    else $error("buffered reload write reached the shadow early");

  // ratio one ticks every cycle, so only longer ratios leave a gap
  presc_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
    counter_tick && !uev && prescale_active != 16'h0000 |=> !counter_tick)
    else $error("prescaler ticked on consecutive cycles");

  stopped_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_enable_off |=> $stable(count_value_reg))
    else $error("counter moved while disabled");

endmodule

`default_nettype wire
